// ===== fcp_map.svh
// Offsets, field positions, reset values and timing counts of the flash controller
// ==========================================================================
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH
// ==========================================================================
// Register addresses
`define FCP_ADDR_COMMAND    8'hb9
`define FCP_ADDR_ACCESS_KEY 8'hb1
`define FCP_ADDR_DATA       8'hbc
`define FCP_ADDR_PROT_KEY   8'hbb
`define FCP_ADDR_WPROT0     8'hbd
`define FCP_ADDR_WPROT1     8'hbe
`define FCP_ADDR_RPROT      8'hbf
`define FCP_ADDR_LOW        8'hc6
`define FCP_ADDR_HIGH       8'hc7
// ==========================================================================
// Values
`define FCP_ACCESS_KEY      8'h3b
`define FCP_ERASED_BYTE     8'hff
`define FCP_KEY_DEFAULT     8'hff
`define FCP_PROT_BASE       14'h3ffa
`define FCP_LAST_PAGE       5'd31
`define FCP_LAST_GROUP      3'd7
`define FCP_WDOG_LOCK_BIT   7
// ==========================================================================
// Timing, clock 200 MHz
`define FCP_CLK_MHZ         200
`define FCP_WRITE_US        30
`define FCP_PAGE_ERASE_MS   20
`define FCP_MASS_ERASE_MS   200
`define FCP_PAGE_WRITE_MS   21
`define FCP_READ_NS         100
`define FCP_CLK_NS          5
`define FCP_WRITE_CYC       (`FCP_WRITE_US * `FCP_CLK_MHZ)
`define FCP_PAGE_ERASE_CYC  (`FCP_PAGE_ERASE_MS * 1000 * `FCP_CLK_MHZ)
`define FCP_MASS_ERASE_CYC  (`FCP_MASS_ERASE_MS * 1000 * `FCP_CLK_MHZ)
`define FCP_PAGE_WRITE_CYC  (`FCP_PAGE_WRITE_MS * 1000 * `FCP_CLK_MHZ)
`define FCP_READ_CYC        (`FCP_READ_NS / `FCP_CLK_NS)
`endif

// ===== fcp_pkg.sv
// Types of the flash controller
package fcp_pkg;
  typedef enum logic [7:0] {
    FCP_CMD_WRITE      = 8'h01,
    FCP_CMD_PAGE_ERASE = 8'h02,
    FCP_CMD_MASS_ERASE = 8'h03,
    FCP_CMD_READ       = 8'h04,
    FCP_CMD_PAGE_WRITE = 8'h05,
    FCP_CMD_PROTECT    = 8'h08
  } fcp_cmd_e;
  typedef enum logic [7:0] {
    FCP_EMU_LOAD  = 8'h49,
    FCP_EMU_STORE = 8'h46
  } fcp_emu_e;
  typedef enum logic [2:0] {
    FCP_IDLE  = 3'b000,
    FCP_ERASE = 3'b001,
    FCP_PROG  = 3'b010,
    FCP_FETCH = 3'b011,
    FCP_MASS  = 3'b100
  } fcp_state_e;
  typedef logic [13:0] fcp_addr_t;
endpackage

// ===== fcp_timer.sv
// Down counter that times one flash operation
`timescale 1ns/1ps
module fcp_timer (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        load_in,
  input  wire logic [31:0] count_in,
  output logic             done_out
);
  logic [31:0] cnt_ff;
  // ==========================================================================
  // Counter, loaded with the cycle count and run down to zero
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_ff <= 32'h0;
    end else if (load_in) begin
      cnt_ff <= count_in;
    end else if (cnt_ff != 32'h0) begin
      cnt_ff <= cnt_ff - 32'h1;
    end
  end
  // Done when the count reaches one, so the operation spans exactly count cycles;
  // kept free of load_in, since the sequencer reloads on done and would loop
  assign done_out = (cnt_ff == 32'h1);
endmodule

// ===== fcp_flash_ctrl.sv
// Flash command sequencer with page protection and download support
`timescale 1ns/1ps
`include "fcp_map.svh"
module fcp_flash_ctrl #(
  parameter int unsigned WRITE_CYC      = `FCP_WRITE_CYC,
  parameter int unsigned PAGE_ERASE_CYC = `FCP_PAGE_ERASE_CYC,
  parameter int unsigned MASS_ERASE_CYC = `FCP_MASS_ERASE_CYC,
  parameter int unsigned PAGE_WRITE_CYC = `FCP_PAGE_WRITE_CYC,
  parameter int unsigned READ_CYC       = `FCP_READ_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sfr_wr_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic [7:0]       sfr_rdata_out,
  input  wire logic        code_read_in,
  input  wire logic [13:0] code_addr_in,
  output logic [7:0]       code_data_out,
  input  wire logic        emu_valid_in,
  input  wire logic [7:0]  emu_cmd_in,
  input  wire logic [7:0]  emu_data_in,
  input  wire logic        download_enable_pin_n_in,
  output logic             download_mode_out,
  output logic             core_stall_out,
  output logic             wdog_lock_out,
  output logic             prot_active_out,
  output logic             cmd_refused_out
);
  import fcp_pkg::*;

  logic [7:0]  mem_ff [0:16383];
  logic [7:0]  flash_data_byte_ff;
  logic [7:0]  flash_addr_low_ff;
  logic [7:0]  flash_addr_high_ff;
  logic [7:0]  protection_key_ff;
  logic [7:0]  read_protect_bits_ff;
  logic [7:0]  write_protect_bits_0_ff;
  logic [7:0]  write_protect_bits_1_ff;
  logic [7:0]  flash_command_ff;
  logic [7:0]  emulator_work_reg_ff;
  logic        key_ok_ff;
  logic [31:0] act_wprot_ff;
  logic [7:0]  act_rprot_ff;
  logic [7:0]  act_key_ff;
  logic        act_on_ff;
  logic        rst_done_ff;
  logic        dl_meta_ff;
  logic        dl_sync_ff;
  logic        download_mode_ff;
  logic        refused_ff;
  logic [7:0]  code_data_ff;
  fcp_state_e  state_ff;
  logic        tmr_load;
  logic [31:0] tmr_count;
  logic        tmr_done;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  fcp_addr_t   sel_addr;
  logic [4:0]  sel_page;
  logic        page_wprot;
  logic        page_rprot;
  logic        cmd_go;
  logic        cmd_ok;
  fcp_cmd_e    cmd;

  // ==========================================================================
  // Register write path, core writes or emulator store command
  assign wr_en   = (sfr_wr_in && !core_stall_out) ||
                   (emu_valid_in && download_mode_ff && emu_cmd_in == FCP_EMU_STORE);
  assign wr_addr = (emu_valid_in && download_mode_ff) ? emu_data_in : sfr_addr_in;
  assign wr_data = (emu_valid_in && download_mode_ff) ? emulator_work_reg_ff : sfr_wdata_in;
  assign sel_addr = {flash_addr_high_ff[5:0], flash_addr_low_ff};
  assign sel_page = sel_addr[13:9];
  assign page_wprot = act_on_ff && !act_wprot_ff[sel_page];
  assign page_rprot = act_on_ff && !act_rprot_ff[sel_page[4:2]];
  assign cmd_go  = wr_en && wr_addr == `FCP_ADDR_COMMAND && state_ff == FCP_IDLE;
  assign cmd     = fcp_cmd_e'(wr_data);

  // Emulator load command fills the working register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      emulator_work_reg_ff <= 8'h0;
    end else if (emu_valid_in && download_mode_ff && emu_cmd_in == FCP_EMU_LOAD) begin
      emulator_work_reg_ff <= emu_data_in;
    end
  end

  // Access key is armed by a correct write and spent by the next register write of any kind
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_ok_ff <= 1'b0;
    end else if (wr_en) begin
      key_ok_ff <= (wr_addr == `FCP_ADDR_ACCESS_KEY) &&
                   (wr_data == `FCP_ACCESS_KEY);
    end
  end

  // Acceptance of a keyed command against protection and download limits
  always_comb begin
    cmd_ok = key_ok_ff;
    unique case (cmd)
      FCP_CMD_WRITE, FCP_CMD_PAGE_ERASE, FCP_CMD_PAGE_WRITE: begin
        if (page_wprot) begin
          cmd_ok = 1'b0;
        end
      end
      FCP_CMD_READ: begin
        if (page_rprot && download_mode_ff) begin
          cmd_ok = 1'b0;
        end
      end
      FCP_CMD_PROTECT: begin
        if (act_key_ff != `FCP_KEY_DEFAULT && protection_key_ff != act_key_ff) begin
          cmd_ok = 1'b0;
        end
      end
      FCP_CMD_MASS_ERASE: begin
        cmd_ok = key_ok_ff;
      end
      default: begin
        cmd_ok = 1'b0;
      end
    endcase
  end

  // Software-visible registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_addr_low_ff       <= 8'h0;
      flash_addr_high_ff      <= 8'h0;
      protection_key_ff       <= `FCP_KEY_DEFAULT;
      read_protect_bits_ff    <= 8'hff;
      write_protect_bits_0_ff <= 8'hff;
      write_protect_bits_1_ff <= 8'hff;
      flash_command_ff        <= 8'h0;
    end else if (wr_en) begin
      unique case (wr_addr)
        `FCP_ADDR_LOW:      flash_addr_low_ff       <= wr_data;
        `FCP_ADDR_HIGH:     flash_addr_high_ff      <= wr_data;
        `FCP_ADDR_PROT_KEY: protection_key_ff       <= wr_data;
        `FCP_ADDR_RPROT:    read_protect_bits_ff    <= wr_data;
        `FCP_ADDR_WPROT0:   write_protect_bits_0_ff <= wr_data;
        `FCP_ADDR_WPROT1:   write_protect_bits_1_ff <= wr_data;
        `FCP_ADDR_COMMAND:  flash_command_ff        <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Data register, written by software or by a completed read command
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_data_byte_ff <= 8'h0;
    end else if (state_ff == FCP_FETCH && tmr_done) begin
      flash_data_byte_ff <= mem_ff[sel_addr];
    end else if (wr_en && wr_addr == `FCP_ADDR_DATA) begin
      flash_data_byte_ff <= wr_data;
    end
  end

  // ==========================================================================
  // Command sequencer; core stalls while busy
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff <= FCP_IDLE;
    end else begin
      unique case (state_ff)
        FCP_IDLE: begin
          if (cmd_go && cmd_ok) begin
            unique case (cmd)
              FCP_CMD_WRITE, FCP_CMD_PROTECT: state_ff <= FCP_PROG;
              FCP_CMD_PAGE_ERASE, FCP_CMD_PAGE_WRITE: state_ff <= FCP_ERASE;
              FCP_CMD_MASS_ERASE: state_ff <= FCP_MASS;
              FCP_CMD_READ: state_ff <= FCP_FETCH;
              default: state_ff <= FCP_IDLE;
            endcase
          end
        end
        FCP_ERASE: begin
          if (tmr_done) begin
            state_ff <= (flash_command_ff == FCP_CMD_PAGE_WRITE) ? FCP_PROG : FCP_IDLE;
          end
        end
        FCP_PROG, FCP_FETCH, FCP_MASS: begin
          if (tmr_done) begin
            state_ff <= FCP_IDLE;
          end
        end
        default: state_ff <= FCP_IDLE;
      endcase
    end
  end

  // Durations; erase-then-write splits its total between the two phases
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = 32'h1;
    if (state_ff == FCP_IDLE && cmd_go && cmd_ok) begin
      tmr_load = 1'b1;
      unique case (cmd)
        FCP_CMD_WRITE, FCP_CMD_PROTECT: tmr_count = WRITE_CYC;
        FCP_CMD_PAGE_ERASE: tmr_count = PAGE_ERASE_CYC;
        FCP_CMD_PAGE_WRITE: tmr_count = PAGE_WRITE_CYC - WRITE_CYC;
        FCP_CMD_MASS_ERASE: tmr_count = MASS_ERASE_CYC;
        FCP_CMD_READ: tmr_count = READ_CYC;
        default: tmr_count = 32'h1;
      endcase
    end else if (state_ff == FCP_ERASE && tmr_done &&
                 flash_command_ff == FCP_CMD_PAGE_WRITE) begin
      tmr_load  = 1'b1;
      tmr_count = WRITE_CYC;
    end
  end

  fcp_timer u_timer (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .load_in    (tmr_load),
    .count_in   (tmr_count),
    .done_out   (tmr_done)
  );

  // Stall is decoded from the registered state, so it rises the cycle after the command write
  assign core_stall_out = (state_ff != FCP_IDLE);

  // ==========================================================================
  // Flash array; programming only clears bits, erase sets them
  always_ff @(posedge clk_in) begin
    if (state_ff == FCP_MASS && tmr_done) begin
      for (int i = 0; i < 16384; i++) begin
        mem_ff[i] <= `FCP_ERASED_BYTE;
      end
    end else if (state_ff == FCP_ERASE && tmr_done) begin
      for (int i = 0; i < 512; i++) begin
        mem_ff[{sel_page, 9'(i)}] <= `FCP_ERASED_BYTE;
      end
    end else if (state_ff == FCP_PROG && tmr_done) begin
      if (flash_command_ff == FCP_CMD_PROTECT) begin
        // Write bits at 0x3FFC..0x3FFF, read byte 0x3FFB, key 0x3FFA
        mem_ff[`FCP_PROT_BASE]       <= mem_ff[`FCP_PROT_BASE] & protection_key_ff;
        mem_ff[`FCP_PROT_BASE + 1]   <= mem_ff[`FCP_PROT_BASE + 1] & read_protect_bits_ff;
        mem_ff[`FCP_PROT_BASE + 2]   <= mem_ff[`FCP_PROT_BASE + 2] & write_protect_bits_0_ff;
        mem_ff[`FCP_PROT_BASE + 3]   <= mem_ff[`FCP_PROT_BASE + 3] & write_protect_bits_1_ff;
        mem_ff[`FCP_PROT_BASE + 4]   <= mem_ff[`FCP_PROT_BASE + 4] & flash_addr_low_ff;
        mem_ff[`FCP_PROT_BASE + 5]   <= mem_ff[`FCP_PROT_BASE + 5] & flash_addr_high_ff;
      end else begin
        mem_ff[sel_addr] <= mem_ff[sel_addr] & flash_data_byte_ff;
      end
    end
  end

  // ==========================================================================
  // Protection snapshot, taken once after reset release
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_done_ff  <= 1'b0;
      act_wprot_ff <= 32'hffffffff;
      act_rprot_ff <= 8'hff;
      act_key_ff   <= `FCP_KEY_DEFAULT;
      act_on_ff    <= 1'b0;
    end else if (!rst_done_ff) begin
      rst_done_ff  <= 1'b1;
      act_wprot_ff <= {mem_ff[`FCP_PROT_BASE + 5], mem_ff[`FCP_PROT_BASE + 4],
                       mem_ff[`FCP_PROT_BASE + 3], mem_ff[`FCP_PROT_BASE + 2]};
      act_rprot_ff <= mem_ff[`FCP_PROT_BASE + 1];
      act_key_ff   <= mem_ff[`FCP_PROT_BASE];
      act_on_ff    <= !mem_ff[`FCP_PROT_BASE + 5][7] &&
                      !mem_ff[`FCP_PROT_BASE + 1][7];
    end
  end
  assign prot_active_out = act_on_ff;
  assign wdog_lock_out   = !act_key_ff[`FCP_WDOG_LOCK_BIT];

  // Download pin synchroniser, free-running so the level held during reset
  // is through both stages when the mode is latched at reset release
  always_ff @(posedge clk_in) begin
    dl_meta_ff <= download_enable_pin_n_in;
    dl_sync_ff <= dl_meta_ff;
  end
  logic dl_taken_ff;
  logic dl_wait_ff;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      download_mode_ff <= 1'b0;
      dl_wait_ff       <= 1'b0;
      dl_taken_ff      <= 1'b0;
    end else if (!dl_taken_ff) begin
      dl_wait_ff <= 1'b1;
      if (dl_wait_ff) begin
        download_mode_ff <= !dl_sync_ff;
        dl_taken_ff      <= 1'b1;
      end
    end
  end
  assign download_mode_out = download_mode_ff;

  // Refusal flag pulses for a command write that was not accepted
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= cmd_go && !cmd_ok;
    end
  end
  assign cmd_refused_out = refused_ff;

  // Code table reads ignore read protection
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      code_data_ff <= 8'h0;
    end else if (code_read_in) begin
      code_data_ff <= mem_ff[code_addr_in];
    end
  end
  assign code_data_out = code_data_ff;

  // Register read mux
  always_comb begin
    unique case (sfr_addr_in)
      `FCP_ADDR_COMMAND:  sfr_rdata_out = flash_command_ff;
      `FCP_ADDR_DATA:     sfr_rdata_out = flash_data_byte_ff;
      `FCP_ADDR_LOW:      sfr_rdata_out = flash_addr_low_ff;
      `FCP_ADDR_HIGH:     sfr_rdata_out = flash_addr_high_ff;
      `FCP_ADDR_PROT_KEY: sfr_rdata_out = protection_key_ff;
      `FCP_ADDR_RPROT:    sfr_rdata_out = read_protect_bits_ff;
      `FCP_ADDR_WPROT0:   sfr_rdata_out = write_protect_bits_0_ff;
      `FCP_ADDR_WPROT1:   sfr_rdata_out = write_protect_bits_1_ff;
      default:            sfr_rdata_out = 8'h0;
    endcase
  end

  // ==========================================================================
  // Checks
  chk_stall_busy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_go && cmd_ok) |=> core_stall_out)
    else $error("stall missing after accepted command");
  chk_no_key_refuse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_go && !key_ok_ff) |=> !core_stall_out && cmd_refused_out)
    else $error("command accepted without key");
  chk_read_time: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_go && cmd_ok && cmd == FCP_CMD_READ) |=> core_stall_out[*8] ##1
    core_stall_out[*8] ##1 core_stall_out[*4] ##1 !core_stall_out)
    else $error("read duration wrong");
  chk_wprot_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_go && page_wprot && cmd == FCP_CMD_WRITE) |=> !core_stall_out)
    else $error("protected page written");
  chk_key_consume: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_en && wr_addr == `FCP_ADDR_COMMAND) |=> !key_ok_ff)
    else $error("key not consumed");
  chk_wdog_lock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wdog_lock_out == !act_key_ff[7])
    else $error("watchdog lock mismatch");
  chk_snap_once: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rst_done_ff |=> $stable(act_wprot_ff) && $stable(act_on_ff))
    else $error("protection changed without reset");
  chk_dl_refuse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_go && download_mode_ff && page_rprot && cmd == FCP_CMD_READ) |=> !core_stall_out)
    else $error("protected read in download");
  cov_write: cover property (@(posedge clk_in) cmd_go && cmd_ok && cmd == FCP_CMD_WRITE);
  cov_page_write: cover property (@(posedge clk_in) state_ff == FCP_ERASE ##1 state_ff == FCP_PROG);
  cov_protect: cover property (@(posedge clk_in) cmd_go && cmd_ok && cmd == FCP_CMD_PROTECT);
  cov_emu: cover property (@(posedge clk_in) emu_valid_in && emu_cmd_in == FCP_EMU_STORE);
endmodule

// ===== fcp_core_model.sv
// Core-side model that issues register writes to the flash controller
`timescale 1ns/1ps
`include "fcp_map.svh"
module fcp_core_model (
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  input  wire logic [7:0] rdata_in,
  output logic            sfr_wr_out,
  output logic [7:0]      sfr_addr_out,
  output logic [7:0]      sfr_wdata_out
);
  int timeouts;
  // Idle bus at time zero
  initial begin
    sfr_wr_out    = 1'b0;
    sfr_addr_out  = 8'h00;
    sfr_wdata_out = 8'h00;
  end
  // One register write, held until an edge that sees the core not stalled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk_in);
    sfr_wr_out    <= 1'b1;
    sfr_addr_out  <= a;
    sfr_wdata_out <= d;
    @(posedge clk_in);
    while (stall_in === 1'b1 && i < 1000) begin
      @(posedge clk_in);
      i++;
    end
    if (i == 1000) begin
      timeouts++;
    end
    sfr_wr_out <= 1'b0;
  endtask
  // Register read, address held one cycle before sampling
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    sfr_addr_out <= a;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
  // Byte address split over the two pointer registers
  task automatic set_addr(input logic [13:0] a);
    wr(`FCP_ADDR_LOW, a[7:0]);
    wr(`FCP_ADDR_HIGH, {2'b00, a[13:8]});
  endtask
  // Fixed key written just before every command
  task automatic cmd(input logic [7:0] code);
    wr(`FCP_ADDR_ACCESS_KEY, `FCP_ACCESS_KEY);
    wr(`FCP_ADDR_COMMAND, code);
  endtask
endmodule

// ===== tb.sv
// Self-checking bench of the flash controller
`timescale 1ns/1ps
`include "fcp_map.svh"
module tb;
  import fcp_pkg::*;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [13:0] addr;
    logic [7:0]  data;
    logic [13:0] chk;
    logic [7:0]  exp;
    logic [7:0]  cyc;
  } fcp_row_s;
  logic        clk_in, sys_rst_in, sfr_wr, code_read, emu_valid, pin_n;
  logic        dl_mode, stall, wdog, active, refused, ref_seen;
  logic [7:0]  sfr_addr, sfr_wdata, rdata, code_data, emu_cmd, emu_data, rd;
  logic [13:0] code_addr;
  int          err_count, compares, n;
  fcp_row_s    rows [6];
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  fcp_core_model core (.clk_in(clk_in), .stall_in(stall), .rdata_in(rdata),
    .sfr_wr_out(sfr_wr), .sfr_addr_out(sfr_addr), .sfr_wdata_out(sfr_wdata));
  fcp_flash_ctrl #(.WRITE_CYC(4), .PAGE_ERASE_CYC(40), .MASS_ERASE_CYC(80),
    .PAGE_WRITE_CYC(50)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .sfr_wr_in(sfr_wr), .sfr_addr_in(sfr_addr), .sfr_wdata_in(sfr_wdata),
    .sfr_rdata_out(rdata), .code_read_in(code_read), .code_addr_in(code_addr),
    .code_data_out(code_data), .emu_valid_in(emu_valid), .emu_cmd_in(emu_cmd),
    .emu_data_in(emu_data), .download_enable_pin_n_in(pin_n),
    .download_mode_out(dl_mode), .core_stall_out(stall), .wdog_lock_out(wdog),
    .prot_active_out(active), .cmd_refused_out(refused));
  // Report and end
  task automatic print_verdict();
    err_count += core.timeouts;
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compare and count
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, e, g);
    end
  endtask
  // Reset with the download pin at a chosen level
  task automatic do_reset(input logic pin);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    pin_n <= pin;
    repeat (9) @(posedge clk_in);
    #1;
    check("reset outputs", 4'h0, {stall, refused, active, wdog});
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
  endtask
  // Keyed command; cyc 0 means refused, negative means length not checked
  task automatic run(input logic [7:0] code, input int cyc);
    core.cmd(code);
    #1;
    ref_seen = refused;
    n = 0;
    while (stall === 1'b1 && n < 1000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n == 1000) begin
      err_count++;
      print_verdict();
    end
    check("refused", 32'(cyc == 0), 32'(ref_seen));
    if (cyc >= 0) check("stall cycles", cyc, n);
  endtask
  // One emulator command, valid for a single cycle
  task automatic emu_op(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_in);
    emu_valid <= 1'b1;
    emu_cmd   <= c;
    emu_data  <= d;
    @(posedge clk_in);
    emu_valid <= 1'b0;
  endtask
  // Table read of one flash byte
  task automatic code_chk(input logic [13:0] a, input logic [7:0] e);
    @(posedge clk_in);
    code_read <= 1'b1;
    code_addr <= a;
    @(posedge clk_in);
    code_read <= 1'b0;
    #1;
    check("code byte", e, code_data);
  endtask
  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    code_read  = 1'b0;
    code_addr  = 14'h0000;
    emu_valid  = 1'b0;
    emu_cmd    = 8'h00;
    emu_data   = 8'h00;
    pin_n      = 1'b1;
    rows[0] = '{8'h01, 14'h3c00, 8'hf3, 14'h3c00, 8'hf3, 8'h04};
    rows[1] = '{8'h01, 14'h3c01, 8'h12, 14'h3c01, 8'h12, 8'h04};
    rows[2] = '{8'h01, 14'h3c00, 8'h0f, 14'h3c00, 8'h03, 8'h04};
    rows[3] = '{8'h05, 14'h3c00, 8'ha5, 14'h3c01, 8'hff, 8'h32};
    rows[4] = '{8'h04, 14'h3c00, 8'h00, 14'h3c00, 8'ha5, 8'h14};
    rows[5] = '{8'h02, 14'h3c00, 8'h00, 14'h3c00, 8'hff, 8'h28};
    do_reset(1'b1);
    run(FCP_CMD_MASS_ERASE, 80);
    do_reset(1'b1);
    check("idle outputs", 4'h0, {stall, refused, active, wdog});
    code_chk(14'h3fff, 8'hff);
    for (int i = 0; i < 6; i++) begin
      core.wr(`FCP_ADDR_DATA, rows[i].data);
      core.set_addr(rows[i].addr);
      run(rows[i].cmd, int'(rows[i].cyc));
      if (rows[i].cmd == 8'h04) begin
        core.rd(`FCP_ADDR_DATA, rd);
        check("data reg", rows[i].exp, rd);
      end else begin
        code_chk(rows[i].chk, rows[i].exp);
      end
    end
    // Key disarmed by another write, then an unknown code
    core.wr(`FCP_ADDR_ACCESS_KEY, `FCP_ACCESS_KEY);
    core.wr(`FCP_ADDR_DATA, 8'h55);
    core.wr(`FCP_ADDR_COMMAND, 8'h01);
    #1;
    check("refused no key", 1, refused);
    run(8'h07, 0);
    code_chk(14'h3c00, 8'hff);
    // Protect last page, key 23h
    core.wr(`FCP_ADDR_WPROT0, 8'hff);
    core.wr(`FCP_ADDR_WPROT1, 8'hff);
    core.wr(`FCP_ADDR_LOW, 8'hff);
    core.wr(`FCP_ADDR_HIGH, 8'h7f);
    core.wr(`FCP_ADDR_RPROT, 8'h7f);
    core.wr(`FCP_ADDR_PROT_KEY, 8'h23);
    run(FCP_CMD_PROTECT, -1);
    check("active before reset", 0, active);
    code_chk(14'h3fff, 8'h7f);
    code_chk(14'h3ffb, 8'h7f);
    code_chk(14'h3ffa, 8'h23);
    do_reset(1'b1);
    check("active", 1, active);
    check("wdog lock", 1, wdog);
    core.set_addr(14'h3e00);
    run(FCP_CMD_WRITE, 0);
    code_chk(14'h3ffa, 8'h23);
    core.set_addr(14'h0000);
    core.wr(`FCP_ADDR_DATA, 8'h5a);
    run(FCP_CMD_WRITE, 4);
    code_chk(14'h0000, 8'h5a);
    core.wr(`FCP_ADDR_PROT_KEY, 8'h11);
    run(FCP_CMD_PROTECT, 0);
    // Download mode: protected read refused, emulator register write
    do_reset(1'b0);
    check("download mode", 1, dl_mode);
    core.set_addr(14'h3e00);
    run(FCP_CMD_READ, 0);
    emu_op(FCP_EMU_LOAD, 8'h6c);
    emu_op(FCP_EMU_STORE, `FCP_ADDR_DATA);
    core.rd(`FCP_ADDR_DATA, rd);
    check("emulator store", 8'h6c, rd);
    // Mass erase lifts protection after reset
    do_reset(1'b1);
    run(FCP_CMD_MASS_ERASE, 80);
    do_reset(1'b1);
    check("active after erase", 0, active);
    code_chk(14'h3fff, 8'hff);
    print_verdict();
  end
endmodule
